/* File: logic/vbi_ctrl_regs.svh */
// Register offsets, field positions, reset values and timing counts for the VBI control block.
`ifndef VBI_CTRL_REGS_SVH
`define VBI_CTRL_REGS_SVH
`define ADDR_COPY_WIDE_CONTROL_0 5'h16
`define ADDR_COPY_WIDE_DATA_1 5'h17
`define ADDR_COPY_WIDE_DATA_2 5'h18
`define ADDR_TEXT_REQUEST_TIMING 5'h19
`define RST_COPY_WIDE_CONTROL_0 8'h00
`define RST_COPY_WIDE_DATA_1 8'h00
`define RST_COPY_WIDE_DATA_2 8'h00
`define RST_TEXT_REQUEST_TIMING 8'h00
`define BIT_CRC_AUTO 4
`define BIT_ODD_COPY 5
`define BIT_EVEN_COPY 6
`define BIT_WIDESCREEN 7
`define LINE_COPY_ODD 10'h014
`define LINE_COPY_EVEN 10'h11b
`define LINE_WIDESCREEN 10'h017
`define TEXT_BITS_DEFAULT 9'h168
`define TEXT_BIT_CYCLES 4'h2
`define CRC_PRESET 6'h3f
`define COPY_BITS 5'h14
`define WIDE_BITS 5'h0e
`define BIT_CYCLES 8'h40
`endif

/* File: logic/vbi_ctrl_pkg.sv */
// Types shared by the VBI control block.
package vbi_ctrl_pkg;
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic line_start;
    logic odd_field;
    logic pal_mode;
    logic [9:0] line_num;
    logic text_line;
  } video_timing_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF = 2'b01,
    ST_DATA = 2'b11
  } send_state_t;
endpackage

/* File: logic/vbi_cgms_wss_teletext_ctrl.sv */
// VBI control: teletext request timing and copy management / widescreen data insertion.
// How it works
// - Request rise is delayed by the upper timing nibble, zero to fifteen clocks.
// - Request fall is advanced by the lower timing nibble, zero to fifteen clocks.
// - Zero fall setting gives a 360-bit window; larger settings shorten it.
// - With fall setting zero, the fall tracks the rise so width stays constant.
// - Control register low nibble feeds only the last four copy bits.
// - Auto CRC bit set computes last six copy bits; clear sends register values.
// - Odd-field copy enable inserts copy data in odd fields, NTSC only.
// - Even-field copy enable inserts copy data in even fields, NTSC only.
// - Widescreen enable inserts widescreen data, PAL only.
// - Data 1 bits 5..0 and data 2 are copy payload in NTSC, widescreen in PAL.
// - Data 1 bits 7..6 are copy data only, ignored for widescreen.
// - Each register is eight bits at its own five-bit subaddress.
// - CRC uses x^6+x+1, preset all ones, over lower fourteen payload bits.
// - Copy data on lines 20 and 283, after a one-bit reference pulse.
// - Widescreen is fourteen bits on line 23 after run-in, data 2 bits first.
// - Copy bit order: data 2 low, data 1 middle, control nibble top.
`timescale 1ns/1ps
`include "vbi_ctrl_regs.svh"
module vbi_cgms_wss_teletext_ctrl (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire vbi_ctrl_pkg::reg_req_t I_REG_REQ,
  input wire vbi_ctrl_pkg::video_timing_t I_TIMING,
  output logic [7:0] O_REG_RDATA,
  output logic O_TEXT_REQUEST_OUT,
  output logic O_VBI_DATA,
  output logic O_VBI_ACTIVE
);
  import vbi_ctrl_pkg::*;

  logic [7:0] ctl_r, ctl_nxt, d1_r, d1_nxt, d2_r, d2_nxt, tim_r, tim_nxt, rdata_r, rdata_nxt;

  // Register file.
  always_comb begin
    ctl_nxt = ctl_r;
    d1_nxt = d1_r;
    d2_nxt = d2_r;
    tim_nxt = tim_r;
    rdata_nxt = 8'h00;
    if (I_REG_REQ.addr == `ADDR_COPY_WIDE_CONTROL_0) begin
      rdata_nxt = ctl_r;
      if (I_REG_REQ.we) ctl_nxt = I_REG_REQ.wdata;
    end else if (I_REG_REQ.addr == `ADDR_COPY_WIDE_DATA_1) begin
      rdata_nxt = d1_r;
      if (I_REG_REQ.we) d1_nxt = I_REG_REQ.wdata;
    end else if (I_REG_REQ.addr == `ADDR_COPY_WIDE_DATA_2) begin
      rdata_nxt = d2_r;
      if (I_REG_REQ.we) d2_nxt = I_REG_REQ.wdata;
    end else if (I_REG_REQ.addr == `ADDR_TEXT_REQUEST_TIMING) begin
      rdata_nxt = tim_r;
      if (I_REG_REQ.we) tim_nxt = I_REG_REQ.wdata;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      ctl_r <= `RST_COPY_WIDE_CONTROL_0;
      d1_r <= `RST_COPY_WIDE_DATA_1;
      d2_r <= `RST_COPY_WIDE_DATA_2;
      tim_r <= `RST_TEXT_REQUEST_TIMING;
      rdata_r <= 8'h00;
    end else begin
      ctl_r <= ctl_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
      tim_r <= tim_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Teletext request window. The nominal window is 360 bits of two clocks each;
  // the rise delay shifts the whole window and the fall setting cuts its end.
  localparam logic [10:0] TEXT_SPAN = 11'(`TEXT_BITS_DEFAULT) * 11'(`TEXT_BIT_CYCLES);
  logic [10:0] tcnt_r, tcnt_nxt;
  logic tact_r, tact_nxt, treq_r, treq_nxt;
  logic [10:0] rise_at, fall_at;

  always_comb begin
    rise_at = {7'h00, tim_r[7:4]};
    // The end is measured from the rise, so a zero fall setting follows the rise.
    fall_at = rise_at + TEXT_SPAN - {7'h00, tim_r[3:0]};
    tcnt_nxt = tcnt_r;
    tact_nxt = tact_r;
    if (I_TIMING.line_start) begin
      tact_nxt = I_TIMING.text_line;
      tcnt_nxt = 11'h000;
    end else if (tact_r) begin
      tcnt_nxt = tcnt_r + 11'h001;
      if (tcnt_r == fall_at) tact_nxt = 1'b0;
    end
    treq_nxt = tact_r && (tcnt_r >= rise_at) && (tcnt_r < fall_at);
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tcnt_r <= 11'h000;
      tact_r <= 1'b0;
      treq_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tact_r <= tact_nxt;
      treq_r <= treq_nxt;
    end
  end

  // CRC over the lower fourteen copy payload bits, bit 0 first.
  function automatic logic [5:0] copy_crc(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = `CRC_PRESET;
    for (int i = 0; i < 14; i++) begin
      fb = c[5] ^ d[i];
      c = {c[4:0], 1'b0} ^ {4'h0, fb, fb};
    end
    return c;
  endfunction

  // Word assembly and serial sender.
  logic [19:0] copy_word, shift_r, shift_nxt;
  logic [13:0] wide_word;
  logic [5:0] crc_val;
  logic copy_line, wide_line;
  send_state_t st_r, st_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [7:0] bcnt_r, bcnt_nxt;
  logic data_r, data_nxt, act_r, act_nxt;

  always_comb begin
    crc_val = copy_crc({d1_r[5:0], d2_r});
    copy_word = {ctl_r[3:0], d1_r, d2_r};
    if (ctl_r[`BIT_CRC_AUTO]) copy_word[19:14] = crc_val;
    wide_word = {d1_r[5:0], d2_r};
    copy_line = !I_TIMING.pal_mode &&
      ((I_TIMING.odd_field && ctl_r[`BIT_ODD_COPY] && I_TIMING.line_num == `LINE_COPY_ODD) ||
       (!I_TIMING.odd_field && ctl_r[`BIT_EVEN_COPY] && I_TIMING.line_num == `LINE_COPY_EVEN));
    wide_line = I_TIMING.pal_mode && ctl_r[`BIT_WIDESCREEN] &&
      I_TIMING.line_num == `LINE_WIDESCREEN;
    st_nxt = st_r;
    shift_nxt = shift_r;
    bits_nxt = bits_r;
    bcnt_nxt = bcnt_r;
    data_nxt = data_r;
    act_nxt = act_r;
    case (st_r)
      ST_IDLE: begin
        data_nxt = 1'b0;
        act_nxt = 1'b0;
        if (I_TIMING.line_start && (copy_line || wide_line)) begin
          // Words are captured here so later writes cannot tear them.
          shift_nxt = copy_line ? copy_word : {6'h00, wide_word};
          bits_nxt = copy_line ? `COPY_BITS : `WIDE_BITS;
          bcnt_nxt = 8'h00;
          st_nxt = ST_REF;
          act_nxt = 1'b1;
          data_nxt = 1'b1; // Reference pulse or run-in marker.
        end
      end
      ST_REF: begin
        bcnt_nxt = bcnt_r + 8'h01;
        if (bcnt_r == `BIT_CYCLES - 8'h01) begin
          bcnt_nxt = 8'h00;
          st_nxt = ST_DATA;
          data_nxt = shift_r[0];
        end
      end
      default: begin
        bcnt_nxt = bcnt_r + 8'h01;
        if (bcnt_r == `BIT_CYCLES - 8'h01) begin
          bcnt_nxt = 8'h00;
          shift_nxt = {1'b0, shift_r[19:1]};
          bits_nxt = bits_r - 5'h01;
          data_nxt = shift_r[1];
          if (bits_r == 5'h01) begin
            st_nxt = ST_IDLE;
            data_nxt = 1'b0;
            act_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      st_r <= ST_IDLE;
      shift_r <= 20'h00000;
      bits_r <= 5'h00;
      bcnt_r <= 8'h00;
      data_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      shift_r <= shift_nxt;
      bits_r <= bits_nxt;
      bcnt_r <= bcnt_nxt;
      data_r <= data_nxt;
      act_r <= act_nxt;
    end
  end

  assign O_REG_RDATA = rdata_r;
  assign O_TEXT_REQUEST_OUT = treq_r;
  assign O_VBI_DATA = data_r;
  assign O_VBI_ACTIVE = act_r;

  property p_req_rise;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      tact_r && tcnt_r == rise_at && rise_at < fall_at |=> treq_r;
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("request not raised at rise delay");
  property p_req_early;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      tact_r && tcnt_r < rise_at |=> !treq_r;
  endproperty
  a_req_early: assert property (p_req_early) else $error("request raised too early");
  property p_req_fall;
    @(posedge I_MCLK) disable iff (!I_RST_N) tcnt_r == fall_at |=> !treq_r;
  endproperty
  a_req_fall: assert property (p_req_fall) else $error("request not dropped at fall");
  // Checker helper: cycles the request has stood high so far.
  logic [10:0] wcnt_r, wcnt_nxt;
  always_comb begin
    wcnt_nxt = treq_r ? wcnt_r + 11'h001 : 11'h000;
  end
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      wcnt_r <= 11'h000;
    end else begin
      wcnt_r <= wcnt_nxt;
    end
  end
  // A window cut short by a new line start is excluded by the counter test.
  property p_width;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      $fell(treq_r) && tcnt_r == fall_at + 11'h001 |->
      wcnt_r == TEXT_SPAN - {7'h00, tim_r[3:0]};
  endproperty
  a_width: assert property (p_width) else $error("window width not kept");
  property p_copy_pal;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      st_r == ST_IDLE && I_TIMING.line_start && I_TIMING.pal_mode &&
      I_TIMING.line_num != `LINE_WIDESCREEN |=> !act_r;
  endproperty
  a_copy_pal: assert property (p_copy_pal) else $error("copy line in PAL mode");
  property p_wide_ntsc;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      st_r == ST_IDLE && I_TIMING.line_start && !I_TIMING.pal_mode &&
      I_TIMING.line_num == `LINE_WIDESCREEN |=> !act_r;
  endproperty
  a_wide_ntsc: assert property (p_wide_ntsc) else $error("widescreen line in NTSC mode");
  property p_crc_off;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      st_r == ST_IDLE && I_TIMING.line_start && copy_line && !ctl_r[`BIT_CRC_AUTO] &&
      !I_REG_REQ.we |=> shift_r[19:16] == ctl_r[3:0];
  endproperty
  a_crc_off: assert property (p_crc_off) else $error("tail bits not from register");
  sequence s_start;
    st_r == ST_IDLE && I_TIMING.line_start && (copy_line || wide_line);
  endsequence
  property p_ref;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      s_start |=> (act_r && data_r) [*8];
  endproperty
  a_ref: assert property (p_ref) else $error("reference pulse missing");
  property p_crc_on;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      st_r == ST_IDLE && I_TIMING.line_start && copy_line && ctl_r[`BIT_CRC_AUTO] &&
      !I_REG_REQ.we |=> shift_r[19:14] == copy_crc({d1_r[5:0], d2_r});
  endproperty
  a_crc_on: assert property (p_crc_on) else $error("crc not inserted");
endmodule

/* File: dv/text_source_model.sv */
// Teletext source model that hands out one bit every two clocks while requested.
`timescale 1ns/1ps
module text_source_model (
  input wire logic i_clk,
  input wire logic i_request,
  output logic o_bit,
  output int o_cycles
);
  logic req_d = 1'b0;
  initial o_bit = 1'b0;
  initial o_cycles = 0;
  // The bit flips once per finished two-clock bit, so its level tells the bit parity.
  always @(posedge i_clk) begin
    req_d <= i_request;
    if (i_request && !req_d) begin
      o_cycles <= 1;
      o_bit <= 1'b0;
    end else if (i_request) begin
      o_cycles <= o_cycles + 1;
      if (o_cycles[0]) o_bit <= ~o_bit;
    end
  end
endmodule

/* File: dv/vbi_cgms_wss_teletext_ctrl_test.sv */
// Self-checking bench for the VBI control block.
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module vbi_cgms_wss_teletext_ctrl_test;
  import vbi_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t req = '0;
  video_timing_t tim = '0;
  logic [7:0] rdata;
  logic text_req, vdata, vact, src_bit;
  int src_cycles;
  int err_total = 0;
  int compares = 0;
  logic [7:0] tcs [4] = '{8'h30, 8'h35, 8'h50, 8'h0f};
  always #2.5 clk = ~clk;
  vbi_cgms_wss_teletext_ctrl dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_REG_REQ(req),
    .I_TIMING(tim), .O_REG_RDATA(rdata), .O_TEXT_REQUEST_OUT(text_req),
    .O_VBI_DATA(vdata), .O_VBI_ACTIVE(vact));
  text_source_model src (.i_clk(clk), .i_request(text_req), .o_bit(src_bit),
    .o_cycles(src_cycles));
  task stop_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, a, d};
    @(negedge clk);
    req.we = 1'b0;
  endtask
  task pulse(input logic odd, pal, txt, input logic [9:0] num);
    @(negedge clk);
    tim = '{1'b1, odd, pal, num, txt};
    @(negedge clk);
    tim.line_start = 1'b0;
  endtask
  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = 6'h3f;
    for (int i = 0; i < 14; i++) begin
      fb = d[i] ^ c[5];
      c = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
    return c;
  endfunction
  task t_regs;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      req.addr = 5'h16 + 5'(i);
      @(negedge clk);
      `CHK("reset", 8'h00, rdata)
      wr(5'h16 + 5'(i), 8'h5a ^ 8'(i * 17));
      @(negedge clk);
      req.addr = 5'h16 + 5'(i);
      @(negedge clk);
      `CHK("rdata", (i < 4) ? 8'h5a ^ 8'(i * 17) : 8'h00, rdata)
    end
    $display("register test done");
  endtask
  task t_text(input logic [7:0] tc);
    int n;
    int w;
    wr(5'h19, tc);
    pulse(1'b0, 1'b0, 1'b1, 10'h00a);
    n = 0;
    w = 0;
    while (text_req !== 1'b1 && n < 40) begin @(negedge clk); n++; end
    `CHK("rise", int'(tc[7:4]) + 1, n)
    while (text_req === 1'b1 && w < 800) begin @(negedge clk); w++; end
    `CHK("width", 720 - int'(tc[3:0]), w)
    `CHK("bits", (720 - int'(tc[3:0])) / 2, src_cycles / 2)
    `CHK("bit phase", 1'((720 - int'(tc[3:0])) / 2), src_bit)
    $display("request test %h done", tc);
  endtask
  task t_text_off;
    logic seen;
    seen = 1'b0;
    pulse(1'b0, 1'b0, 1'b0, 10'h00a);
    repeat (40) begin @(negedge clk); seen = seen | text_req; end
    `CHK("no request", 1'b0, seen)
    $display("request off test done");
  endtask
  task send(input logic odd, pal, input logic [9:0] num, input int nb, input logic [19:0] e);
    logic [19:0] got;
    int k;
    got = '0;
    k = 0;
    pulse(odd, pal, 1'b0, num);
    while (vact !== 1'b1 && k < 4) begin @(negedge clk); k++; end
    `CHK("active", nb != 0, vact)
    if (vact === 1'b1) begin
      repeat (32) @(negedge clk);
      `CHK("reference", 1'b1, vdata)
      for (k = 0; k < nb; k++) begin
        repeat (64) @(negedge clk);
        got[k] = vdata;
      end
      `CHK("word", e, got)
      repeat (40) @(negedge clk);
      `CHK("idle", 1'b0, vact)
    end
    $display("insertion test line %0d done", num);
  endtask
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    foreach (tcs[i]) t_text(tcs[i]);
    t_text_off;
    wr(5'h16, 8'h2a);
    wr(5'h17, 8'hc3);
    wr(5'h18, 8'h96);
    // A write in mid-word must not reach the word on the wire.
    fork
      send(1'b1, 1'b0, 10'h014, 20, {4'ha, 8'hc3, 8'h96});
      begin repeat (100) @(negedge clk); wr(5'h18, 8'h3c); end
    join
    wr(5'h16, 8'h5a);
    send(1'b0, 1'b0, 10'h11b, 20, {crc6(14'h033c), 6'h03, 8'h3c});
    send(1'b1, 1'b0, 10'h014, 0, 20'h0);
    send(1'b0, 1'b1, 10'h11b, 0, 20'h0);
    wr(5'h16, 8'h8f);
    send(1'b0, 1'b1, 10'h017, 14, {6'h00, 6'h03, 8'h3c});
    send(1'b0, 1'b0, 10'h017, 0, 20'h0);
    stop_test;
  end
endmodule
